// *** touch_slider_burst_sequencer_test.sv ***
// self-checking bench for the slider burst sequencer
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module touch_slider_burst_sequencer_test;
  localparam int FR = 200;
  logic clk = 1'b0, nrst = 1'b0, hand_near_in = 1'b0, touch_in = 1'b0, burst_done = 1'b0;
  logic [6:0] pos_in = 7'h00, position;
  logic [7:0] resp_byte;
  logic sel_n_in, sclk_in, sel_n_out, sel_n_oe, burst_start, drift_step, hand_near;
  logic hand_near_oe, touch, touch_oe, ready_to_talk, ready_to_talk_oe, position_valid, asleep;
  int miscompares = 0, compares = 0, cycles = 0, bursts = 0, drifts = 0, slp = 0, n, i;
  int nclk[4] = '{0, 3, 0, 8};
  int hold[4] = '{7000, 7010, 8000, 7020};
  always #2.5 clk = ~clk;
  tsb_sequencer #(.FREERUN_CYC(FR), .FLOAT_CYC(100)) dut_u (
    .clk(clk), .nrst(nrst), .sel_n_in(sel_n_in), .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe),
    .sclk_in(sclk_in), .hand_near_in(hand_near_in), .touch_in(touch_in), .pos_in(pos_in),
    .burst_done(burst_done), .burst_start(burst_start), .drift_step(drift_step),
    .hand_near(hand_near), .hand_near_oe(hand_near_oe), .touch(touch), .touch_oe(touch_oe),
    .ready_to_talk(ready_to_talk), .ready_to_talk_oe(ready_to_talk_oe), .position(position),
    .position_valid(position_valid), .resp_byte(resp_byte), .asleep(asleep)
  );
  tsb_host host_u (
    .clk(clk), .ready_to_talk(ready_to_talk), .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe),
    .sel_n_in(sel_n_in), .sclk_in(sclk_in)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (asleep === 1'b1) slp++;
    if (drift_step === 1'b1) drifts++;
    if (cycles == 90000) begin
      miscompares++;
      test_done();
    end
  end
  // front end: ends every burst; ends of the strip come first
  initial begin
    void'($urandom(62056));
    forever begin
      @(posedge clk);
      if (burst_start === 1'b1) begin
        {touch_in, hand_near_in, pos_in} <= bursts < 2 ? (bursts ? 9'h17f : 9'h100) : 9'($urandom);
        bursts++;
        repeat ($urandom_range(12, 3)) @(posedge clk);
        burst_done <= 1'b1;
        @(posedge clk);
        burst_done <= 1'b0;
        repeat (3) @(posedge clk);
        check({touch, hand_near}, {touch_in, hand_near_in});
        check(position, touch_in ? pos_in : 7'h00);
        check(resp_byte, touch_in ? {1'b1, pos_in} : {7'h00, hand_near_in});
      end
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    while (burst_done !== 1'b1) @(posedge clk);
    n = 0;
    while (burst_start !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(8'(n > FR - 4 && n < FR + 4), 8'h01);
    while (bursts < 190) @(posedge clk);
    check(8'(drifts), 8'h01);
    check(8'(slp), 8'h00);
    // a select fall inside a free-run burst is ignored, so start just after one
    while (burst_done !== 1'b1) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      host_u.frame(nclk[i], hold[i]);
      check(asleep, 1'b1);
      repeat (10) @(posedge clk);
      check({hand_near_oe, touch_oe, ready_to_talk_oe}, 8'h00);
      repeat (120) @(posedge clk);
      check({hand_near_oe, touch_oe, ready_to_talk_oe}, 8'h07);
    end
    test_done();
  end
endmodule // touch_slider_burst_sequencer_test
bind tsb_sequencer tsb_checker chk_u (
  .clk(clk), .nrst(nrst), .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe),
  .burst_start(burst_start), .hand_near(hand_near), .touch(touch), .touch_oe(touch_oe),
  .ready_to_talk(ready_to_talk), .ready_to_talk_oe(ready_to_talk_oe), .position(position),
  .position_valid(position_valid), .resp_byte(resp_byte), .asleep(asleep)
);
`default_nettype wire

// *** tsb_checker.sv ***
// port assertions for the slider burst sequencer
`timescale 1ns/1ps
`default_nettype none
// ====
// checker
module tsb_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sel_n_out,
  input wire logic sel_n_oe,
  input wire logic burst_start,
  input wire logic hand_near,
  input wire logic touch,
  input wire logic touch_oe,
  input wire logic ready_to_talk,
  input wire logic ready_to_talk_oe,
  input wire logic [6:0] position,
  input wire logic position_valid,
  input wire logic [7:0] resp_byte,
  input wire logic asleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  resp_touch_a: assert property (touch |-> resp_byte == {1'b1, position})
    else $error("response byte wrong while touched");
  resp_near_a: assert property (!touch |-> resp_byte == {7'h00, hand_near})
    else $error("response byte wrong while untouched");
  pos_gate_a: assert property (position_valid == touch && (touch || position == 7'h00))
    else $error("position shown without touch");
  clamp_len_a: assert property ($rose(sel_n_oe) |-> sel_n_oe [*8] ##[35:50] !sel_n_oe)
    else $error("select clamp length wrong");
  wake_clamp_a: assert property ($fell(asleep) |-> ##[0:2] (sel_n_oe && !sel_n_out))
    else $error("no select clamp on wake");
  wake_float_a: assert property ($fell(asleep) |-> ##2 !(touch_oe || ready_to_talk_oe))
    else $error("status pins driven on wake");
  wake_burst_a: assert property ($fell(asleep) |-> ##[1:3] burst_start)
    else $error("no burst after wake");
  sleep_quiet_a: assert property (asleep |-> !burst_start)
    else $error("burst during sleep");
  ready_busy_a: assert property (burst_start |-> ##[0:1] !ready_to_talk)
    else $error("ready high while bursting");
  cover property ($fell(asleep));
  cover property (touch && position == 7'h7f);
  cover property (!touch && hand_near);
endmodule // tsb_checker
`default_nettype wire

// *** tsb_defines.vh ***
// timing and encoding constants for the touch slider burst sequencer
`ifndef TSB_DEFINES_VH
`define TSB_DEFINES_VH

`define TSB_CLK_MHZ 200
`define TSB_SLEEP_US 35
`define TSB_SLEEP_CYC ((`TSB_SLEEP_US * `TSB_CLK_MHZ) - 1)
`define TSB_SYNC_LAG 5
`define TSB_FLOAT_US 400
`define TSB_FLOAT_CYC (`TSB_FLOAT_US * `TSB_CLK_MHZ)
`define TSB_CLAMP_NS 250
`define TSB_CLAMP_CYC ((`TSB_CLAMP_NS * `TSB_CLK_MHZ) / 1000)
`define TSB_FREERUN_MS 60
`define TSB_FREERUN_CYC (`TSB_FREERUN_MS * 1000 * `TSB_CLK_MHZ)
`define TSB_DRIFT_BURSTS 180
`define TSB_POS_W 7
`define TSB_POS_MAX 7'h7f
`define TSB_RESP_TOUCH_BIT 7
`define TSB_RESP_NEAR_BIT 0

`endif

// *** tsb_host.sv ***
// host model: drives select and serial clock
`timescale 1ns/1ps
`default_nettype none
// ====
// host
module tsb_host (
  input wire logic clk,
  input wire logic ready_to_talk,
  input wire logic sel_n_out,
  input wire logic sel_n_oe,
  output logic sel_n_in,
  output logic sclk_in
);
  logic sel_drv = 1'b1;
  initial sclk_in = 1'b1;
  // host drives through a series resistor, so the clamp wins
  assign sel_n_in = sel_n_oe ? sel_n_out : sel_drv;
  task automatic frame(input int nclk, input int hold);
    int i;
    i = 0;
    while (ready_to_talk !== 1'b1 && i < 100000) begin
      @(posedge clk);
      i++;
    end
    sel_drv <= 1'b0;
    repeat (8) @(posedge clk);
    for (i = 0; i < nclk; i++) begin
      sclk_in <= 1'b0;
      repeat (2) @(posedge clk);
      sclk_in <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (hold) @(posedge clk);
    sel_drv <= 1'b1;
    @(posedge clk);
  endtask
endmodule // tsb_host
`default_nettype wire

// *** tsb_sequencer.v ***
// acquisition sequencing, sleep and host handshake of the touch slider
// Behaviour
// [RULE1] position is unsigned 7 bits, left 0
// [RULE2] sync mode: select fall then rise, burst
// [RULE3] host restarts burst within one second
// [RULE4] sleep within 35us of last clock rise
// [RULE5] host raises select after 35us only
// [RULE6] select rise wakes and starts burst
// [RULE7] host may delay select to save power
// [RULE8] select held high: burst every 60ms
// [RULE9] free-run mode never sleeps between bursts
// [RULE10] free-run drift: one count per 180 bursts
// [RULE11] status outputs float 400us after wake
// [RULE12] select clamped low 250ns on wake
// [RULE13] host idles serial clock high
// [RULE14] serial clock ignored while select high
// [RULE15] ready output high when talk possible
// [RULE16] near output high while hand near
// [RULE17] touch output high while strip touched
// [RULE18] host may pace transactions to mains
// [RULE19] host gives sensors separate burst slots
// [RULE20] position reported only while touched
// [RULE21] response byte: touch bit7, near bit0
// [RULE22] host enforces 35us and one-second limits
`timescale 1ns/1ps
`default_nettype none
`include "tsb_defines.vh"

module tsb_sequencer #(
  parameter FREERUN_CYC = `TSB_FREERUN_CYC,
  parameter FLOAT_CYC = `TSB_FLOAT_CYC
) (
  input wire clk,
  input wire nrst,
  input wire sel_n_in,
  output reg sel_n_out,
  output reg sel_n_oe,
  input wire sclk_in,
  input wire hand_near_in,
  input wire touch_in,
  input wire [6:0] pos_in,
  input wire burst_done,
  output reg burst_start,
  output reg drift_step,
  output reg hand_near,
  output reg hand_near_oe,
  output reg touch,
  output reg touch_oe,
  output reg ready_to_talk,
  output reg ready_to_talk_oe,
  output reg [6:0] position,
  output reg position_valid,
  output reg [7:0] resp_byte,
  output reg asleep
);
  // ==========================================================
  // reset release and pin synchronisers
  reg rst_a;
  reg rst_b;
  wire rst_n;
  wire sel_s;
  wire sclk_s;
  assign rst_n = rst_b;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end

  tsb_sync3 #(.INIT(1'b1)) u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .din(sel_n_in),
    .dout(sel_s)
  );

  tsb_sync3 #(.INIT(1'b1)) u_sclk (
    .clk(clk),
    .rst_n(rst_n),
    .din(sclk_in),
    .dout(sclk_s)
  );

  // ==========================================================
  // edge detection
  reg sel_d;
  reg sclk_d;
  wire sel_fall;
  wire sel_rise;
  wire sclk_rise;
  assign sel_fall = sel_d & ~sel_s;
  assign sel_rise = ~sel_d & sel_s;
  // clock edges only count inside a select-low frame
  assign sclk_rise = ~sclk_d & sclk_s & ~sel_s; // [RULE14]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      sel_d <= sel_s;
      sclk_d <= sclk_s;
    end
  end

  // ==========================================================
  // sequencer
  localparam ST_FREE = 3'h0;
  localparam ST_BURST = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_FRAME = 3'h3;
  localparam ST_SLEEP = 3'h4;
  localparam ST_WAKE = 3'h5;

  localparam [31:0] SLEEP_CYC = `TSB_SLEEP_CYC;
  // pin-to-edge delay of the synchroniser, taken off the sleep budget
  localparam [31:0] SYNC_LAG = `TSB_SYNC_LAG;
  localparam [31:0] CLAMP_CYC = `TSB_CLAMP_CYC;
  localparam [7:0] DRIFT_N = `TSB_DRIFT_BURSTS;

  reg [2:0] state;
  reg sync_mode;
  reg [31:0] timer;
  reg [31:0] float_cnt;
  reg [31:0] clamp_cnt;
  reg [7:0] drift_cnt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_FREE;
      sync_mode <= 1'b0;
      timer <= 32'h0;
      float_cnt <= 32'h0;
      clamp_cnt <= 32'h0;
      drift_cnt <= 8'h0;
      burst_start <= 1'b0;
      drift_step <= 1'b0;
      asleep <= 1'b0;
      sel_n_out <= 1'b0;
      sel_n_oe <= 1'b0;
    end else begin
      burst_start <= 1'b0;
      drift_step <= 1'b0;
      if (float_cnt != 32'h0) begin
        float_cnt <= float_cnt - 32'h1;
      end
      if (clamp_cnt != 32'h0) begin
        clamp_cnt <= clamp_cnt - 32'h1;
      end
      sel_n_oe <= (clamp_cnt != 32'h0); // [RULE12]
      case (state)
        ST_FREE: begin
          // free-run pacing, no sleep in between
          if (sel_fall) begin
            sync_mode <= 1'b1;
            timer <= 32'h0;
            state <= ST_FRAME;
          end else if (timer >= FREERUN_CYC - 1) begin
            timer <= 32'h0;
            burst_start <= 1'b1; // [RULE8] [RULE9]
            state <= ST_BURST;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        ST_BURST: begin
          if (burst_done) begin
            timer <= 32'h0;
            if (!sync_mode) begin
              // reference creep capped at one count per batch
              if (drift_cnt == DRIFT_N - 8'h1) begin
                drift_cnt <= 8'h0;
                drift_step <= 1'b1; // [RULE10]
              end else begin
                drift_cnt <= drift_cnt + 8'h1;
              end
              state <= ST_FREE;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          // sync mode waits for the host; held-high select falls back to free run
          if (sel_fall) begin
            state <= ST_FRAME;
            timer <= 32'h0;
          end else if (timer >= FREERUN_CYC - 1) begin
            sync_mode <= 1'b0;
            timer <= 32'h0;
            state <= ST_FREE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        ST_FRAME: begin
          // sleep 35us after the last clock, or after the fall if none came;
          // sleeping at once would drop clocks that are still on their way
          if (sclk_rise) begin
            timer <= 32'h0;
          end else if (timer >= SLEEP_CYC - SYNC_LAG - 32'h1) begin
            timer <= 32'h0;
            state <= ST_SLEEP; // [RULE4]
            asleep <= 1'b1;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        ST_SLEEP: begin
          if (sel_rise) begin
            asleep <= 1'b0; // [RULE6]
            float_cnt <= FLOAT_CYC;
            clamp_cnt <= CLAMP_CYC;
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          burst_start <= 1'b1; // [RULE2] [RULE6]
          state <= ST_BURST;
        end
        default: begin
          state <= ST_FREE;
        end
      endcase
    end
  end

  // ==========================================================
  // status pins, float window and response byte
  wire floating;
  assign floating = (float_cnt != 32'h0);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hand_near <= 1'b0;
      touch <= 1'b0;
      ready_to_talk <= 1'b0;
      hand_near_oe <= 1'b0;
      touch_oe <= 1'b0;
      ready_to_talk_oe <= 1'b0;
      position <= 7'h00;
      position_valid <= 1'b0;
      resp_byte <= 8'h00;
    end else begin
      hand_near_oe <= ~floating & ~asleep; // [RULE11]
      touch_oe <= ~floating & ~asleep; // [RULE11]
      ready_to_talk_oe <= ~floating & ~asleep; // [RULE11]
      hand_near <= hand_near_in; // [RULE16]
      touch <= touch_in; // [RULE17]
      // talk is possible whenever no burst is running or being started from wake
      ready_to_talk <= (state != ST_BURST) && (state != ST_WAKE); // [RULE15]
      position_valid <= touch_in; // [RULE20]
      position <= touch_in ? pos_in : 7'h00; // [RULE1] [RULE20]
      resp_byte <= touch_in ? {1'b1, pos_in} : {7'h00, hand_near_in}; // [RULE21]
    end
  end
endmodule // tsb_sequencer

`default_nettype wire

// *** tsb_sync3.v ***
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module tsb_sync3 #(
  parameter INIT = 1'b0
) (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // tsb_sync3

`default_nettype wire
